// File: rtl/rlx_ctl.sv
// receive error substitution, carrier sense and loopback transmit gating
// =====================================================================
`timescale 1ns/1ps
`include "rlx_map.svh"

module rlx_ctl #(
  parameter int unsigned PKT_TIMEOUT_CYC = `RLX_PKT_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [`RLX_MGMT_AW-1:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  input wire logic full_duplex,
  input wire logic basic_ctl_loopback,
  input wire logic line_rx_activity,
  input wire logic link_err,
  input wire logic sym_valid,
  input wire logic [4:0] sym,
  input wire logic [3:0] rxd_in,
  input wire logic rx_dv_in,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic crs,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic line_tx_active,
  output logic [3:0] line_tx_pair
);
  import rlx_pkg::*;

  localparam int unsigned CW = $clog2(PKT_TIMEOUT_CYC + 1);

  logic [15:0] lbrem;
  logic [15:0] next_lbrem;
  logic [15:0] next_mgmt_rdata;
  logic [3:0] rxd_d;
  logic rx_dv_d;
  logic link_err_d;
  logic code_err;
  logic premature_end_select;
  logic [CW-1:0] pkt_cnt;
  logic [CW-1:0] next_pkt_cnt;
  logic pkt_to;
  logic next_pkt_to;
  logic next_crs;
  logic [3:0] next_rxd;
  logic next_rx_dv;
  logic next_rx_er;
  logic next_line_tx_active;
  logic [3:0] next_line_tx_pair;
  logic lb_any;
  logic lb_active;
  rlx_lb_mode_t lb_mode;

  rlx_sym_mon u_sym_mon (
    .clk(clk),
    .srst(srst),
    .sym_valid(sym_valid),
    .sym(sym),
    .code_err(code_err),
    .premature_end_select(premature_end_select)
  );

  // =====================================================================
  // management register
  always_comb begin
    next_lbrem = lbrem;
    if (mgmt_wr && mgmt_addr == `RLX_LBREM_ADDR) begin
      // reserved bit 0 is stored as written; software ignores it
      next_lbrem = mgmt_wdata & `RLX_LBREM_WMASK;
    end
    next_mgmt_rdata = (mgmt_addr == `RLX_LBREM_ADDR) ? lbrem : 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lbrem <= `RLX_LBREM_RESET;
      mgmt_rdata <= 16'h0000;
    end else begin
      lbrem <= next_lbrem;
      mgmt_rdata <= next_mgmt_rdata;
    end
  end

  // =====================================================================
  // packet timeout on a long receive
  always_comb begin
    next_pkt_cnt = pkt_cnt;
    next_pkt_to = pkt_to;
    if (!rx_dv_in) begin
      next_pkt_cnt = '0;
      next_pkt_to = 1'b0;
    end else if (pkt_cnt == CW'(PKT_TIMEOUT_CYC)) begin
      next_pkt_to = 1'b1;
    end else begin
      next_pkt_cnt = pkt_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pkt_cnt <= '0;
      pkt_to <= 1'b0;
    end else begin
      pkt_cnt <= next_pkt_cnt;
      pkt_to <= next_pkt_to;
    end
  end

  // =====================================================================
  // mii outputs and line transmit
  always_comb begin
    lb_mode = rlx_lb_mode_t'(lbrem[`RLX_LSB_LB_MODE +: 2]);
    // transceiver loopback is active with basic_ctl_loopback or the XCVR mode, whatever the other bits
    lb_active = basic_ctl_loopback || lb_mode == RLX_LB_XCVR;
    lb_any = lb_active || lb_mode == RLX_LB_REMOTE;

    // carrier sense
    if (full_duplex) begin
      if (lbrem[`RLX_BIT_ALT_CRS]) begin
        next_crs = tx_en;
      end else begin
        next_crs = line_rx_activity;
      end
    end else begin
      next_crs = line_rx_activity | tx_en;
    end

    // receive nibble, two cycles behind the symbol stream
    next_rxd = rxd_d;
    next_rx_dv = rx_dv_d;
    next_rx_er = 1'b0;
    if (basic_ctl_loopback) begin
      next_rxd = rxd_d;
    end
    if (lbrem[`RLX_BIT_BP_ALIGN]) begin
      next_rx_er = 1'b0;
    end else if (code_err) begin
      next_rx_er = 1'b1;
      next_rxd = lbrem[`RLX_BIT_CODE_SEL] ? `RLX_NIB_CODE_ONE
                                           : `RLX_NIB_DEFAULT;
    end else if (premature_end_select) begin
      next_rx_er = 1'b1;
      next_rxd = lbrem[`RLX_BIT_PE_SEL] ? `RLX_NIB_PE_ONE
                                         : `RLX_NIB_DEFAULT;
    end else if (link_err_d && lbrem[`RLX_BIT_LINK_RPT]) begin
      next_rx_er = 1'b1;
      next_rxd = `RLX_NIB_LINK;
    end else if (pkt_to && lbrem[`RLX_BIT_PKT_RPT]) begin
      next_rx_er = 1'b1;
      next_rxd = `RLX_NIB_PKT;
    end

    // line transmit, gated during transceiver loopback when the transmit disable bit is set
    next_line_tx_pair = txd;
    next_line_tx_active = tx_en;
    if (lb_mode == RLX_LB_REMOTE && !basic_ctl_loopback) begin
      next_line_tx_pair = rxd_d;
      next_line_tx_active = rx_dv_d;
    end
    if (lb_active && lbrem[`RLX_BIT_LBK_TX_DIS]) begin
      next_line_tx_active = 1'b0;
      next_line_tx_pair = 4'h0;
    end
  end

  // transceiver loopback replaces receive data with own transmit data
  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_d <= 4'h0;
      rx_dv_d <= 1'b0;
      link_err_d <= 1'b0;
    end else if (lb_active) begin
      rxd_d <= txd;
      rx_dv_d <= tx_en;
      // link error aligned with the delayed data nibble
      link_err_d <= link_err;
    end else begin
      rxd_d <= rxd_in;
      rx_dv_d <= rx_dv_in;
      link_err_d <= link_err;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      crs <= 1'b0;
      rxd <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      line_tx_active <= 1'b0;
      line_tx_pair <= 4'h0;
    end else begin
      crs <= next_crs;
      rxd <= next_rxd;
      rx_dv <= next_rx_dv;
      rx_er <= next_rx_er;
      line_tx_active <= next_line_tx_active;
      line_tx_pair <= next_line_tx_pair;
    end
  end

  // lb_any is not used by the remote mode decision above; tied off here
  logic unused_lb_any;
  assign unused_lb_any = lb_any;

endmodule // rlx_ctl

// File: rtl/rlx_map.svh
// offsets, field positions, reset values and timing for the error mask block
`ifndef RLX_MAP_SVH
`define RLX_MAP_SVH

// =====================================================================
// register map
`define RLX_MGMT_AW 5
`define RLX_LBREM_ADDR 5'h18
`define RLX_LBREM_RESET 16'h0020
`define RLX_LBREM_WMASK 16'h1B7F

// =====================================================================
// field positions
`define RLX_BIT_BP_ALIGN 12
`define RLX_LSB_LB_MODE 8
`define RLX_BIT_ALT_CRS 6
`define RLX_BIT_LBK_TX_DIS 5
`define RLX_BIT_CODE_SEL 4
`define RLX_BIT_PE_SEL 3
`define RLX_BIT_LINK_RPT 2
`define RLX_BIT_PKT_RPT 1

// =====================================================================
// substituted receive nibbles
`define RLX_NIB_CODE_ONE 4'h5
`define RLX_NIB_PE_ONE 4'h4
`define RLX_NIB_DEFAULT 4'h6
`define RLX_NIB_LINK 4'h3
`define RLX_NIB_PKT 4'h2

// =====================================================================
// 5b code groups
`define RLX_SYM_IDLE 5'h1F
`define RLX_SYM_J 5'h18
`define RLX_SYM_K 5'h11
`define RLX_SYM_T 5'h0D
`define RLX_SYM_R 5'h07

// =====================================================================
// timing
`define RLX_CLK_PERIOD_NS 10
`define RLX_PKT_TIMEOUT_US 722
`define RLX_PKT_TIMEOUT_CYC \
  ((`RLX_PKT_TIMEOUT_US * 1000) / `RLX_CLK_PERIOD_NS)

`endif

// File: rtl/rlx_pkg.sv
// types shared by the error mask block
package rlx_pkg;

  typedef enum logic [1:0] {
    RLX_LB_NORMAL,
    RLX_LB_XCVR,
    RLX_LB_REMOTE,
    RLX_LB_RSVD
  } rlx_lb_mode_t;

  typedef enum logic [1:0] {
    RLX_ST_IDLE,
    RLX_ST_GOT_J,
    RLX_ST_FRAME,
    RLX_ST_GOT_T
  } rlx_mon_state_t;

endpackage

// File: rtl/rlx_sym_mon.sv
// receive symbol stream monitor: code and premature end errors
`timescale 1ns/1ps
`include "rlx_map.svh"

module rlx_sym_mon (
  input wire logic clk,
  input wire logic srst,
  input wire logic sym_valid,
  input wire logic [4:0] sym,
  output logic code_err,
  output logic premature_end_select
);
  import rlx_pkg::*;

  rlx_mon_state_t state;
  rlx_mon_state_t next_state;
  logic idle_seen;
  logic next_idle_seen;
  logic next_code_err;
  logic next_premature_end_select;

  // true for the sixteen data code groups
  function automatic logic is_data(input logic [4:0] s);
    case (s)
      5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
      5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C,
      5'h1D: is_data = 1'b1;
      default: is_data = 1'b0;
    endcase
  endfunction

  // =====================================================================
  // delimiter tracking
  always_comb begin
    next_state = state;
    next_idle_seen = 1'b0;
    next_code_err = 1'b0;
    next_premature_end_select = 1'b0;
    if (sym_valid) begin
      case (state)
        RLX_ST_IDLE: begin
          if (sym == `RLX_SYM_J) begin
            next_state = RLX_ST_GOT_J;
          end
        end
        RLX_ST_GOT_J: begin
          next_state = (sym == `RLX_SYM_K) ? RLX_ST_FRAME : RLX_ST_IDLE;
        end
        RLX_ST_FRAME: begin
          if (sym == `RLX_SYM_T) begin
            next_state = RLX_ST_GOT_T;
          end else if (sym == `RLX_SYM_IDLE) begin
            // second idle in a row before the T/R pair ends the frame early
            if (idle_seen) begin
              next_premature_end_select = 1'b1;
              next_state = RLX_ST_IDLE;
            end else begin
              next_idle_seen = 1'b1;
            end
          end else if (!is_data(sym)) begin
            next_code_err = 1'b1;
          end
        end
        RLX_ST_GOT_T: begin
          if (sym == `RLX_SYM_R) begin
            next_state = RLX_ST_IDLE;
          end else begin
            next_code_err = 1'b1;
            next_state = RLX_ST_FRAME;
          end
        end
        default: next_state = RLX_ST_IDLE;
      endcase
    end else begin
      next_idle_seen = idle_seen;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= RLX_ST_IDLE;
      idle_seen <= 1'b0;
      code_err <= 1'b0;
      premature_end_select <= 1'b0;
    end else begin
      state <= next_state;
      idle_seen <= next_idle_seen;
      code_err <= next_code_err;
      premature_end_select <= next_premature_end_select;
    end
  end

endmodule // rlx_sym_mon

// File: verif/rlx_ctl_assertions.sv
// port checker for the error mask block
`timescale 1ns/1ps
`include "rlx_map.svh"
module rlx_ctl_chk #(
  parameter int unsigned PKT_TIMEOUT_CYC = `RLX_PKT_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic full_duplex,
  input wire logic basic_ctl_loopback,
  input wire logic line_rx_activity,
  input wire logic link_err,
  input wire logic sym_valid,
  input wire logic [4:0] sym,
  input wire logic rx_dv_in,
  input wire logic tx_en,
  input wire logic crs,
  input wire logic [3:0] rxd,
  input wire logic rx_er,
  input wire logic line_tx_active,
  input wire logic [3:0] line_tx_pair
);
  logic [15:0] r;
  logic nl;
  int unsigned dv_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ==================================================================
  // register shadow and valid run length
  always_ff @(posedge clk) begin
    if (srst)
      r <= `RLX_LBREM_RESET;
    else if (mgmt_wr && mgmt_addr == `RLX_LBREM_ADDR)
      r <= mgmt_wdata & `RLX_LBREM_WMASK;
    dv_cnt <= (srst || !rx_dv_in) ? 0 : dv_cnt + 1;
  end
  assign nl = !basic_ctl_loopback && r[9:8] == 2'h0 && !r[12];
  sequence s_jk;
    (sym_valid && sym == `RLX_SYM_J) ##1 (sym_valid && sym == `RLX_SYM_K);
  endsequence
  sequence s_idle2;
    (sym_valid && sym == `RLX_SYM_IDLE && nl) [*2];
  endsequence
  property p_crs_alt;
    full_duplex && r[6] && nl |=> crs == $past(tx_en);
  endproperty
  a_crs_alt: assert property (p_crs_alt) else $error("crs alt");
  property p_crs_rx;
    full_duplex && !r[6] && nl |=> crs == $past(line_rx_activity);
  endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("crs rx");
  property p_lb_off;
    basic_ctl_loopback && r[5] |=> !line_tx_active && line_tx_pair == 4'h0;
  endproperty
  a_lb_off: assert property (p_lb_off) else $error("line tx");
  property p_code;
    s_jk ##2 (sym_valid && sym == 5'h00 && nl) |=> ##1 rx_er &&
      rxd == ($past(r[4], 2) ? `RLX_NIB_CODE_ONE : `RLX_NIB_DEFAULT);
  endproperty
  a_code: assert property (p_code) else $error("code nibble");
  property p_pe;
    s_jk ##2 s_idle2 |=> ##1 rx_er &&
      rxd == ($past(r[3], 2) ? `RLX_NIB_PE_ONE : `RLX_NIB_DEFAULT);
  endproperty
  a_pe: assert property (p_pe) else $error("pe nibble");
  property p_link;
    (link_err && r[2] && nl && !sym_valid) [*2] |=>
      rx_er && rxd == `RLX_NIB_LINK;
  endproperty
  a_link: assert property (p_link) else $error("link nibble");
  property p_pkt;
    (dv_cnt > PKT_TIMEOUT_CYC + 2 && r[1] && !link_err && nl) [*2] |=>
      rx_er && rxd == `RLX_NIB_PKT;
  endproperty
  a_pkt: assert property (p_pkt) else $error("pkt nibble");
  property p_bypass;
    r[12] [*3] |-> !rx_er;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass");
endmodule // rlx_ctl_chk

bind rlx_ctl rlx_ctl_chk #(.PKT_TIMEOUT_CYC(PKT_TIMEOUT_CYC)) chk_u (.*);

// File: verif/rlx_mac_bfm.sv
// transmit side of the MAC on the MII
`timescale 1ns/1ps
module rlx_mac_bfm (
  input wire logic clk,
  input wire logic go,
  output logic tx_en,
  output logic [3:0] txd
);
  initial begin
    tx_en = 1'h0;
    txd = 4'h0;
  end
  // idle data is inverted every cycle so a stale nibble is never mistaken
  always @(posedge clk) begin
    #1;
    tx_en <= go;
    txd <= go ? 4'($urandom) : ~txd;
  end
endmodule // rlx_mac_bfm

// File: verif/tb_top.sv
// self-checking bench for the error mask block
`timescale 1ns/1ps
`include "rlx_map.svh"
module tb_top;
  localparam int P = 20;
  logic clk = 1'h0, srst = 1'h1, mgmt_wr = 1'h0, go = 1'h0;
  logic full_duplex = 1'h0, basic_ctl_loopback = 1'h0, link_err = 1'h0;
  logic line_rx_activity = 1'h0, sym_valid = 1'h0, rx_dv_in = 1'h0;
  logic tx_en, crs, rx_er, rx_dv, line_tx_active;
  logic [4:0] mgmt_addr = 5'h18, sym = 5'h1F;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, rg = 16'h0020;
  logic [3:0] rxd_in = 4'h0, txd, rxd, line_tx_pair;
  int err_total = 0, samples_checked = 0, fr = 0, idl = 0, dvc = 0;
  int rxon = 1;
  int q[$] = '{-1};
  rlx_ctl #(.PKT_TIMEOUT_CYC(P)) dut_u (.*);
  rlx_mac_bfm mac_u (.*);
  always #5 clk = ~clk;
  // ==================================================================
  // receive model: -1 means not compared
  function automatic int mdl();
    int e;
    e = rxd_in;
    dvc = rx_dv_in ? dvc + 1 : 0;
    if (!rg[12] && (basic_ctl_loopback || rg[9:8] == 2'h1))
      return txd + 32 * tx_en;
    if (!rxon || basic_ctl_loopback || rg[9:8] != 2'h0) return -1;
    if (sym_valid) begin
      if (sym != `RLX_SYM_IDLE) idl = 0;
      if (fr == 2 && sym == 5'h00) e = 16 + (rg[4] ? 5 : 6);
      if (fr == 2 && sym == `RLX_SYM_IDLE && ++idl == 2) begin
        e = 16 + (rg[3] ? 4 : 6);
        fr = 0;
      end
      if (sym == `RLX_SYM_J) fr = 1;
      else if (fr == 1) fr = sym == `RLX_SYM_K ? 2 : 0;
      else if (sym == `RLX_SYM_T) fr = 0;
    end
    if (e < 16 && link_err && rg[2]) e = 16 + 3;
    else if (e < 16 && rg[1]) e = dvc > P + 3 ? 16 + 2 : -1;
    e = rg[12] ? rxd_in : e;
    return e < 0 ? e : e + 32 * rx_dv_in;
  endfunction
  task automatic cmp(logic [15:0] a, int e);
    samples_checked++;
    if (a !== e[15:0]) begin
      err_total++;
      $display("unexpected %0t got %h exp %h", $time, a, e[15:0]);
    end
  endtask
  task automatic tick();
    int e;
    logic c, g;
    logic [4:0] lt;
    @(negedge clk);
    e = mdl();
    c = full_duplex ? (rg[6] ? tx_en : line_rx_activity) : line_rx_activity | tx_en;
    g = (basic_ctl_loopback || rg[9:8] == 2'h1) && rg[5];
    lt = g ? 5'h00 : {tx_en, tx_en ? txd : 4'h0};
    q.push_back(e);
    @(posedge clk);
    #1;
    e = q.pop_front();
    if (e >= 0) cmp({rx_dv, rx_er, rxd}, e);
    if (!basic_ctl_loopback && rg[9:8] == 2'h0) cmp(crs, c);
    if (!rg[9]) cmp({line_tx_active, lt[4] || g ? line_tx_pair : 4'h0}, lt);
  endtask
  task automatic rdc(logic [4:0] a);
    mgmt_addr = a;
    tick();
    tick();
    cmp(mgmt_rdata & 16'hFFFE, a == 5'h18 ? rg & 16'hFFFE : 0);
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'h1;
    tick();
    mgmt_wr = 1'h0;
    if (a == `RLX_LBREM_ADDR) rg = d & `RLX_LBREM_WMASK;
    rdc(a);
  endtask
  task automatic frame(logic [4:0] x, logic [4:0] y);
    logic [4:0] f [8];
    f = '{`RLX_SYM_J, `RLX_SYM_K, 5'h0E, x, y, `RLX_SYM_T, `RLX_SYM_R,
      `RLX_SYM_IDLE};
    foreach (f[k]) begin
      sym_valid = 1'h1;
      sym = f[k];
      rxd_in = 4'($urandom);
      tick();
    end
    sym_valid = 1'h0;
  endtask
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #20us;
    err_total++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h08BA));
    repeat (10) @(posedge clk);
    #1;
    srst = 1'h0;
    rdc(5'h18);
    wr(5'h19, 16'($urandom) & 16'hFFFE);
    wr(5'h18, 16'hFFFE);
    for (int i = 0; i < 5; i++) begin
      wr(5'h18, i < 4 ? 16'(i) << 3 : 16'h1018);
      frame(5'h00, 5'h0E);
      frame(`RLX_SYM_IDLE, `RLX_SYM_IDLE);
    end
    for (int i = 0; i < 4; i++) begin
      wr(5'h18, 16'(i) << 1);
      link_err = i != 1;
      rx_dv_in = 1'h1;
      repeat (P + 8) tick();
      link_err = 1'h0;
      rx_dv_in = 1'h0;
      repeat (3) tick();
    end
    rxon = 0;
    for (int i = 0; i < 10; i++) begin
      full_duplex = i[1];
      basic_ctl_loopback = i[2];
      wr(5'h18, i < 8 ? 16'(i[0]) * 16'h0060 : 16'(i - 8) << 8);
      repeat (12) begin
        go = 1'($urandom);
        line_rx_activity = 1'($urandom);
        tick();
      end
    end
    finish_test();
  end
endmodule // tb_top
